// *** shared/gpb_pkg.sv ***
// package of constants and types for the gpio port bank
package gpb_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int GPB_DATA_W = 8;
  localparam int GPB_ADDR_W = 4;
  localparam int GPB_PA_W = 6;
  localparam int GPB_PB_W = 8;
  localparam int GPB_ACFG_W = 5;
  localparam int GPB_CHG_W = 4;
  localparam int GPB_MISC_W = 3;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0] ADR_PIN_A = 4'h0;
  localparam logic [3:0] ADR_LAT_A = 4'h1;
  localparam logic [3:0] ADR_DIR_A = 4'h2;
  localparam logic [3:0] ADR_PIN_B = 4'h3;
  localparam logic [3:0] ADR_LAT_B = 4'h4;
  localparam logic [3:0] ADR_DIR_B = 4'h5;
  localparam logic [3:0] ADR_ACFG = 4'h6;
  localparam logic [3:0] ADR_ICTL = 4'h7;
  localparam logic [3:0] ADR_ICTL2 = 4'h8;
  localparam logic [3:0] ADR_MISC = 4'h9;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_LAT = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [4:0] RST_ACFG = 5'h1f;
  localparam logic [2:0] RST_MISC = 3'h2;
  localparam logic [7:0] PA_MASK = 8'h3f;

  // ****************************************
  // field positions
  // ****************************************
  localparam int FLAG_BIT = 0;
  localparam int PU_N_BIT = 7;
  localparam int MISC_COMPARATOR_REF_OUT = 0;
  localparam int MISC_ROUTE = 1;
  localparam int MISC_EXT = 2;
  localparam int PA_T0_PIN = 4;
  localparam int PA_COMPARATOR_REF_OUT_PIN = 2;
  localparam int PB_CH2_PIN = 3;
  localparam int PB_CHG_LO = 4;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] out;
    logic [7:0] oe;
  } gpb_periph_t;

  typedef struct packed {
    logic [7:0] lat_a;
    logic [7:0] dir_a;
    logic [7:0] lat_b;
    logic [7:0] dir_b;
    logic [4:0] acfg;
    logic flag;
    logic pu_n;
    logic [2:0] misc;
    logic [3:0] old_b;
    logic [7:0] rd_data;
  } gpb_state_t;

endpackage : gpb_pkg

// *** hw/gpb_port.sv ***
// one port's pin drive and input path
`timescale 1ns/100ps
module gpb_port
  import gpb_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic [W-1:0] dir, // direction bits, 1 = input
  input wire logic [W-1:0] lat, // output latch
  input wire logic [W-1:0] periph_en, // peripheral owns pin
  input wire logic [W-1:0] periph_out, // peripheral data
  input wire logic [W-1:0] periph_oe, // peripheral drive enable
  input wire logic [W-1:0] dig_off, // digital input disabled
  input wire logic [W-1:0] out_off, // digital output disabled
  input wire logic [W-1:0] pad_in, // pin levels
  output logic [W-1:0] pad_out, // pin drive value
  output logic [W-1:0] pad_oe, // pin drive enable
  output logic [W-1:0] pin_rd // level seen by software
);

  if (W < 1 || W > GPB_DATA_W) begin : g_chk
    $error("gpb_port width out of range");
  end

  // ****************************************
  // drive and sample
  // ****************************************
  always_comb begin
    pad_oe = (periph_en & periph_oe) | (~periph_en & ~dir & ~out_off); // see [R2] see [R6]
    pad_out = (periph_en & periph_out) | (~periph_en & lat & ~out_off); // see [R7]
    pin_rd = pad_in & ~dig_off; // see [R7]
  end

endmodule : gpb_port

// *** hw/gpb_bank.sv ***
// gpio port bank: ports a and b, port b with pull-ups and pin-change detect
//
// What this block does
// [R1] each port has direction, pin and latch registers
// [R2] direction 1 floats pin, 0 drives latch
// [R3] latch reads return latched values
// [R4] pin register reads return pin levels
// [R5] port b eight bits; port a bits 7:6 zero
// [R6] enabled peripheral takes the pin over
// [R7] analog input disables digital input, not output
// [R8] port a analog pins analog after reset
// [R9] a4 digital input, feeds timer zero clock
// [R10] comparator reference output disables a2 digital
// [R11] one active-low bit enables all pull-ups
// [R12] pull-up off while pin drives
// [R13] pull-ups off after reset
// [R14] change detect on b7..b4 inputs only
// [R15] mismatch against last-read copy sets flag
// [R16] port b access refreshes copy, except move
// [R17] flag keeps setting while mismatch lasts
// [R18] pin change flag can wake device
// [R19] software should not poll port b
// [R20] channel two routes to b3 or e7
// [R21] pin register write updates latch
`timescale 1ns/100ps
module gpb_bank
  import gpb_pkg::*;
#(
  parameter bit PINS_80 = 1'b1
) (
  input wire logic mclk, // core clock, 25 MHz
  input wire logic rst, // async reset, active high
  input wire logic [GPB_ADDR_W-1:0] addr, // register address
  input wire logic [GPB_DATA_W-1:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic wr_is_move, // write is a mem-to-mem move
  input wire logic rd_en, // read strobe
  output logic [GPB_DATA_W-1:0] rd_data, // read data, cycle after strobe
  input wire logic [GPB_PA_W-1:0] pad_a_in, // port a pin levels
  output logic [GPB_PA_W-1:0] pad_a_out, // port a drive value
  output logic [GPB_PA_W-1:0] pad_a_oe, // port a drive enable
  input wire logic [GPB_PB_W-1:0] pad_b_in, // port b pin levels
  output logic [GPB_PB_W-1:0] pad_b_out, // port b drive value
  output logic [GPB_PB_W-1:0] pad_b_oe, // port b drive enable
  output logic [GPB_PB_W-1:0] pu_b, // port b weak pull-up on
  input wire gpb_periph_t periph_a, // peripherals on port a
  input wire gpb_periph_t periph_b, // peripherals on port b
  input wire logic ch2_out, // compare/pwm channel two data
  input wire logic ch2_oe, // compare/pwm channel two drive
  output logic port_e_bit7_out, // channel two on e7, value
  output logic port_e_bit7_oe, // channel two on e7, enable
  output logic timer_zero_clock_in, // a4 level to timer zero
  output logic [GPB_ACFG_W-1:0] analog_en, // analog channels selected
  output logic comparator_ref_out, // reference output enabled
  output logic pin_change_flag, // pin change flag
  output logic wake // wake request from pin change
);

  // ****************************************
  // state
  // ****************************************
  gpb_state_t s;
  gpb_state_t next_s;

  logic [GPB_PA_W-1:0] an_a;
  logic [GPB_PA_W-1:0] cv_a;
  logic [GPB_PA_W-1:0] dig_off_a;
  logic [GPB_PA_W-1:0] pin_rd_a;
  logic [GPB_PB_W-1:0] pin_rd_b;
  logic [GPB_PB_W-1:0] ch2_b;
  logic [GPB_PB_W-1:0] en_b;
  logic [GPB_PB_W-1:0] out_b;
  logic [GPB_PB_W-1:0] oe_b;
  logic [GPB_CHG_W-1:0] cur_b;
  logic [GPB_CHG_W-1:0] mism;
  logic ch2_on_b;
  logic ch2_on_e;
  logic touch_b;

  function automatic logic hit(input logic en, input logic [3:0] a, input logic [3:0] r);
    hit = en && (a == r);
  endfunction : hit

  // ****************************************
  // pin mapping
  // ****************************************
  always_comb begin
    an_a = '0;
    an_a[3:0] = s.acfg[3:0];
    an_a[5] = s.acfg[4];
    cv_a = '0;
    cv_a[PA_COMPARATOR_REF_OUT_PIN] = s.misc[MISC_COMPARATOR_REF_OUT]; // see [R10]
    dig_off_a = an_a | cv_a; // see [R7] see [R10]
  end

  // route channel two by mapping bit and bus mode
  always_comb begin
    ch2_on_b = PINS_80 && s.misc[MISC_EXT] && !s.misc[MISC_ROUTE]; // see [R20]
    ch2_on_e = PINS_80 && !s.misc[MISC_EXT] && !s.misc[MISC_ROUTE]; // see [R20]
    ch2_b = '0;
    ch2_b[PB_CH2_PIN] = ch2_on_b;
    en_b = periph_b.en | ch2_b;
    out_b = (periph_b.out & ~ch2_b) | ({GPB_PB_W{ch2_out}} & ch2_b);
    oe_b = (periph_b.oe & ~ch2_b) | ({GPB_PB_W{ch2_oe}} & ch2_b);
  end

  gpb_port #(.W(GPB_PA_W)) u_port_a (
    .dir(s.dir_a[GPB_PA_W-1:0]),
    .lat(s.lat_a[GPB_PA_W-1:0]),
    .periph_en(periph_a.en[GPB_PA_W-1:0]),
    .periph_out(periph_a.out[GPB_PA_W-1:0]),
    .periph_oe(periph_a.oe[GPB_PA_W-1:0]),
    .dig_off(dig_off_a),
    .out_off(cv_a),
    .pad_in(pad_a_in),
    .pad_out(pad_a_out),
    .pad_oe(pad_a_oe),
    .pin_rd(pin_rd_a)
  );

  gpb_port #(.W(GPB_PB_W)) u_port_b (
    .dir(s.dir_b),
    .lat(s.lat_b),
    .periph_en(en_b),
    .periph_out(out_b),
    .periph_oe(oe_b),
    .dig_off('0),
    .out_off('0),
    .pad_in(pad_b_in),
    .pad_out(pad_b_out),
    .pad_oe(pad_b_oe),
    .pin_rd(pin_rd_b)
  );

  // ****************************************
  // side outputs
  // ****************************************
  always_comb begin
    pu_b = ~pad_b_oe & {GPB_PB_W{~s.pu_n}}; // see [R11] see [R12]
    timer_zero_clock_in = pad_a_in[PA_T0_PIN]; // see [R9]
    port_e_bit7_out = ch2_out;
    port_e_bit7_oe = ch2_on_e && ch2_oe;
    analog_en = s.acfg;
    comparator_ref_out = s.misc[MISC_COMPARATOR_REF_OUT];
    pin_change_flag = s.flag;
    wake = s.flag; // see [R18]
    rd_data = s.rd_data;
  end

  // ****************************************
  // change detect
  // ****************************************
  always_comb begin
    cur_b = pin_rd_b[GPB_PB_W-1:PB_CHG_LO];
    mism = (cur_b ^ s.old_b) & s.dir_b[GPB_PB_W-1:PB_CHG_LO]; // see [R14] see [R15]
    touch_b = hit(rd_en, addr, ADR_PIN_B) ||
              (hit(wr_en, addr, ADR_PIN_B) && !wr_is_move); // see [R16]
  end

  // ****************************************
  // register file
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.rd_data = '0;
    if (wr_en) begin
      case (addr)
        ADR_PIN_A, ADR_LAT_A: next_s.lat_a = wr_data & PA_MASK; // see [R21]
        ADR_DIR_A: next_s.dir_a = wr_data & PA_MASK;
        ADR_PIN_B, ADR_LAT_B: next_s.lat_b = wr_data; // see [R21]
        ADR_DIR_B: next_s.dir_b = wr_data;
        ADR_ACFG: next_s.acfg = wr_data[GPB_ACFG_W-1:0];
        ADR_ICTL: next_s.flag = wr_data[FLAG_BIT];
        ADR_ICTL2: next_s.pu_n = wr_data[PU_N_BIT]; // see [R11]
        ADR_MISC: next_s.misc = wr_data[GPB_MISC_W-1:0];
        default: next_s.flag = s.flag;
      endcase
    end
    if (|mism) begin
      next_s.flag = 1'b1; // see [R15] see [R17]
    end
    if (touch_b) begin
      next_s.old_b = cur_b; // see [R16]
    end
    if (rd_en) begin
      case (addr) // see [R1]
        ADR_PIN_A: next_s.rd_data = {2'h0, pin_rd_a}; // see [R4] see [R5]
        ADR_LAT_A: next_s.rd_data = s.lat_a & PA_MASK; // see [R3]
        ADR_DIR_A: next_s.rd_data = s.dir_a & PA_MASK;
        ADR_PIN_B: next_s.rd_data = pin_rd_b; // see [R4]
        ADR_LAT_B: next_s.rd_data = s.lat_b; // see [R3]
        ADR_DIR_B: next_s.rd_data = s.dir_b;
        ADR_ACFG: next_s.rd_data = {3'h0, s.acfg};
        ADR_ICTL: next_s.rd_data = {7'h00, s.flag};
        ADR_ICTL2: next_s.rd_data = {s.pu_n, 7'h00};
        ADR_MISC: next_s.rd_data = {5'h00, s.misc};
        default: next_s.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s.lat_a <= RST_LAT;
      s.dir_a <= RST_DIR & PA_MASK; // see [R9]
      s.lat_b <= RST_LAT;
      s.dir_b <= RST_DIR;
      s.acfg <= RST_ACFG; // see [R8]
      s.flag <= 1'b0;
      s.pu_n <= 1'b1; // see [R13]
      s.misc <= RST_MISC;
      s.old_b <= '0;
      s.rd_data <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_dir_drive;
    (periph_b.en == '0) && !ch2_on_b |-> (pad_b_oe == ~s.dir_b) && (pad_b_out == s.lat_b);
  endproperty
  a_dir_drive: assert property (p_dir_drive) // see [R2]
    else $error("port b drive does not follow direction and latch");

  property p_lat_read;
    rd_en && addr == ADR_LAT_B |=> rd_data == $past(s.lat_b);
  endproperty
  a_lat_read: assert property (p_lat_read) // see [R3]
    else $error("latch read returned wrong value");

  property p_pin_read;
    rd_en && addr == ADR_PIN_B |=> rd_data == $past(pad_b_in);
  endproperty
  a_pin_read: assert property (p_pin_read) // see [R4]
    else $error("pin read did not return pin levels");

  property p_a_upper;
    rd_en && (addr == ADR_PIN_A || addr == ADR_LAT_A || addr == ADR_DIR_A)
      |=> rd_data[7:6] == 2'h0;
  endproperty
  a_a_upper: assert property (p_a_upper) // see [R5]
    else $error("port a upper bits not zero");

  property p_comparator_ref_out_off;
    s.misc[MISC_COMPARATOR_REF_OUT] && !periph_a.en[PA_COMPARATOR_REF_OUT_PIN] |-> !pad_a_oe[PA_COMPARATOR_REF_OUT_PIN];
  endproperty
  a_comparator_ref_out_off: assert property (p_comparator_ref_out_off) // see [R10]
    else $error("a2 driven while reference output on");

  // with no peripheral on port b and pull-ups enabled, pull-ups sit exactly on the input pins
  property p_pu_out;
    (en_b == '0) |-> pu_b == (s.dir_b & {GPB_PB_W{~s.pu_n}});
  endproperty
  a_pu_out: assert property (p_pu_out) // see [R11] see [R12]
    else $error("pull-up on while pin drives");

  property p_pu_reset;
    $past(rst) |-> pu_b == '0;
  endproperty
  a_pu_reset: assert property (p_pu_reset) // see [R13]
    else $error("pull-ups on after reset");

  property p_flag_set;
    |mism |=> pin_change_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) // see [R15]
    else $error("mismatch did not set flag");

  property p_refresh;
    rd_en && addr == ADR_PIN_B |=> s.old_b == $past(pad_b_in[7:4]);
  endproperty
  a_refresh: assert property (p_refresh) // see [R16]
    else $error("port b read did not refresh copy");

  property p_pin_write;
    wr_en && addr == ADR_PIN_B |=> s.lat_b == $past(wr_data);
  endproperty
  a_pin_write: assert property (p_pin_write) // see [R21]
    else $error("pin register write missed latch");

endmodule : gpb_bank

// *** test/gpb_pad_model.sv ***
// pin and board model for one port of the gpio bank
`timescale 1ns/100ps
module gpb_pad_model #(
  parameter int W = 8
) (
  input wire logic mclk, // core clock
  input wire logic [W-1:0] drv_out, // design drive value
  input wire logic [W-1:0] drv_oe, // design drive enable
  input wire logic [W-1:0] pull, // weak pull-up on
  input wire logic [W-1:0] ext_val, // board drive value
  input wire logic [W-1:0] ext_en, // board drives the pin
  output logic [W-1:0] lvl // resolved pin level
);
  logic flip = 1'b0;

  // a floating pin with no pull shows a level that changes every cycle
  always @(posedge mclk) begin
    flip <= ~flip;
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (drv_oe[i])
        lvl[i] = drv_out[i];
      else if (ext_en[i])
        lvl[i] = ext_val[i];
      else if (pull[i])
        lvl[i] = 1'b1;
      else
        lvl[i] = flip;
    end
  end
endmodule : gpb_pad_model

// *** test/gpb_bank_bench.sv ***
// self-checking bench for the gpio port bank
`timescale 1ns/100ps
module gpb_bank_bench
  import gpb_pkg::*;
;
  logic mclk, rst, wr_en, wr_is_move, rd_en, ch2_out, ch2_oe;
  logic [3:0] addr;
  logic [7:0] wr_data, rd_data, pad_b_in, pad_b_out, pad_b_oe, pu_b, ext_b, ext_b_en;
  logic [5:0] pad_a_in, pad_a_out, pad_a_oe, ext_a;
  logic [4:0] analog_en;
  logic port_e_bit7_out, port_e_bit7_oe, timer_zero_clock_in, comparator_ref_out;
  logic pin_change_flag, wake;
  gpb_periph_t periph_a, periph_b;
  int n_fail, n_checks;

  gpb_bank dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .wr_is_move(wr_is_move), .rd_en(rd_en), .rd_data(rd_data), .pad_a_in(pad_a_in),
    .pad_a_out(pad_a_out), .pad_a_oe(pad_a_oe), .pad_b_in(pad_b_in), .pad_b_out(pad_b_out),
    .pad_b_oe(pad_b_oe), .pu_b(pu_b), .periph_a(periph_a), .periph_b(periph_b),
    .ch2_out(ch2_out), .ch2_oe(ch2_oe), .port_e_bit7_out(port_e_bit7_out),
    .port_e_bit7_oe(port_e_bit7_oe), .timer_zero_clock_in(timer_zero_clock_in),
    .analog_en(analog_en), .comparator_ref_out(comparator_ref_out),
    .pin_change_flag(pin_change_flag), .wake(wake));
  gpb_pad_model #(.W(6)) pads_a_u (.mclk(mclk), .drv_out(pad_a_out), .drv_oe(pad_a_oe),
    .pull(6'h00), .ext_val(ext_a), .ext_en(6'h3f), .lvl(pad_a_in));
  gpb_pad_model #(.W(8)) pads_b_u (.mclk(mclk), .drv_out(pad_b_out), .drv_oe(pad_b_oe),
    .pull(pu_b), .ext_val(ext_b), .ext_en(ext_b_en), .lvl(pad_b_in));

  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic mv = 1'b0);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_is_move <= mv;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    wr_is_move <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask : rd

  task automatic complete_run;
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    #100us;
    n_fail++;
    complete_run();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {rst, wr_en, wr_is_move, rd_en, ch2_out, ch2_oe} = 6'h20;
    {addr, wr_data, ext_b, ext_b_en, ext_a} = {4'h0, 8'h00, 8'h00, 8'hff, 6'h3f};
    periph_a = '0;
    periph_b = '0;
    n_fail = 0;
    n_checks = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(ADR_DIR_A, 8'h3f);
    rd(ADR_DIR_B, RST_DIR);
    rd(ADR_LAT_A, RST_LAT);
    rd(ADR_LAT_B, RST_LAT);
    rd(ADR_ACFG, {3'h0, RST_ACFG});
    rd(ADR_ICTL2, 8'h80);
    rd(ADR_MISC, {5'h0, RST_MISC});
    rd(ADR_ICTL, 8'h00);
    wr(ADR_ICTL, 8'h01);
    rd(ADR_ICTL, 8'h01);
    wr(ADR_ICTL, 8'h00);
    rd(4'hf, 8'h00);
    chk(pu_b, 8'h00);
    chk({3'h0, analog_en}, 8'h1f);
    rd(ADR_PIN_A, 8'h10);
    chk({7'h0, timer_zero_clock_in}, 8'h01);
    wr(ADR_LAT_A, 8'h2a);
    wr(ADR_DIR_A, 8'h00);
    @(negedge mclk);
    chk({2'h0, pad_a_oe}, 8'h3f);
    chk({2'h0, pad_a_out}, 8'h2a);
    chk({7'h0, timer_zero_clock_in}, 8'h00);
    wr(ADR_ACFG, 8'h00);
    wr(ADR_DIR_A, 8'h01);
    rd(ADR_PIN_A, 8'h2b);
    rd(ADR_LAT_A, 8'h2a);
    wr(ADR_PIN_A, 8'h15);
    rd(ADR_LAT_A, 8'h15);
    wr(ADR_DIR_A, 8'h00);
    wr(ADR_MISC, 8'h03);
    @(negedge mclk);
    chk({2'h0, pad_a_oe}, 8'h3b);
    chk({7'h0, comparator_ref_out}, 8'h01);
    rd(ADR_PIN_A, 8'h11);
    wr(ADR_MISC, 8'h02);
    periph_a <= '{en: 8'h02, out: 8'h02, oe: 8'h02};
    @(negedge mclk);
    chk({2'h0, pad_a_out}, 8'h17);
    @(posedge mclk);
    periph_a <= '0;
    // port b pull-ups with the board letting go of every pin
    wr(ADR_ICTL2, 8'h00);
    wr(ADR_DIR_B, 8'h0f);
    wr(ADR_LAT_B, 8'ha0);
    ext_b_en <= 8'h00;
    @(negedge mclk);
    chk(pu_b, 8'h0f);
    rd(ADR_PIN_B, 8'haf);
    wr(ADR_ICTL2, 8'h80);
    @(negedge mclk);
    chk(pu_b, 8'h00);
    // reset in mid-run with pull-ups enabled must switch them off
    wr(ADR_ICTL2, 8'h00);
    ext_b_en <= 8'hff;
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk(pu_b, 8'h00);
    rd(ADR_ICTL2, 8'h80);
    // pin change detect
    wr(ADR_DIR_B, 8'hff);
    rd(ADR_PIN_B, 8'h00);
    wr(ADR_ICTL, 8'h00);
    @(negedge mclk);
    chk({7'h0, pin_change_flag}, 8'h00);
    @(posedge mclk);
    ext_b <= 8'h20;
    // wait on the flag instead of polling the port b pins
    repeat (2) @(posedge mclk);
    #1;
    chk({6'h0, wake, pin_change_flag}, 8'h03);
    rd(ADR_ICTL, 8'h01);
    wr(ADR_ICTL, 8'h00);
    @(negedge mclk);
    chk({7'h0, pin_change_flag}, 8'h01);
    wr(ADR_PIN_B, 8'h00, 1'b1);
    wr(ADR_ICTL, 8'h00);
    @(negedge mclk);
    chk({7'h0, pin_change_flag}, 8'h01);
    rd(ADR_PIN_B, 8'h20);
    wr(ADR_ICTL, 8'h00);
    @(negedge mclk);
    chk({7'h0, pin_change_flag}, 8'h00);
    @(posedge mclk);
    ext_b <= 8'h30;
    repeat (2) @(posedge mclk);
    #1;
    chk({7'h0, pin_change_flag}, 8'h01);
    wr(ADR_PIN_B, 8'h00);
    wr(ADR_ICTL, 8'h00);
    @(negedge mclk);
    chk({7'h0, pin_change_flag}, 8'h00);
    @(posedge mclk);
    ext_b <= 8'h3f;
    wr(ADR_DIR_B, 8'h0f);
    repeat (3) @(posedge mclk);
    #1;
    chk({7'h0, pin_change_flag}, 8'h00);
    // peripheral takeover and channel two routing
    @(posedge mclk);
    periph_b <= '{en: 8'h01, out: 8'h01, oe: 8'h01};
    ch2_out <= 1'b1;
    ch2_oe <= 1'b1;
    wr(ADR_MISC, 8'h04);
    @(negedge mclk);
    chk(pad_b_out, 8'h09);
    chk(pad_b_oe, 8'hf9);
    wr(ADR_MISC, 8'h00);
    @(negedge mclk);
    chk({6'h0, port_e_bit7_oe, port_e_bit7_out}, 8'h03);
    complete_run();
  end
endmodule : gpb_bank_bench
